// ---- sdc_channel6.sv ----
// channel-6 register slice, interrupt vector and trim of the converter
`timescale 1ns/10ps
`include "sdc_regs.svh"

module sdc_channel6 #(
  parameter int CHANNELS   = 7,
  parameter int ADDR_WIDTH = 11
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  brown_out_reset_n,
  input  wire logic [ADDR_WIDTH-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [15:0]           avs_writedata,
  input  wire logic [1:0]            avs_byteenable,
  output logic      [15:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [31:0]           filter_output,
  input  wire logic                  result_valid,
  input  wire logic [CHANNELS-1:0]   overflow_flag,
  input  wire logic [CHANNELS-2:0]   other_done_flag,
  input  wire logic                  reference_source_select,
  output logic                       conversion_done_flag,
  output logic                       result_half_select,
  output logic      [4:0]            vector_code,
  output logic                       first_irq_delay_select,
  output logic      [2:0]            first_irq_sample,
  output logic      [2:0]            preamp_gain_code,
  output logic                       gain_code_reserved,
  output logic      [2:0]            input_pair_select,
  output logic                       temp_sensor_selected,
  output logic                       input_code_reserved,
  output logic      [7:0]            filter_preload_value,
  output logic      [1:0]            reference_delay_trim,
  output logic      [1:0]            applied_delay_trim,
  output logic      [2:0]            bias_current_trim
);

  // ========================================================================
  // address decode helper
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] addr,
                               input logic [8:0]            idx);
    hit = (addr == {idx, 2'b00});
  endfunction : hit

  // ========================================================================
  // declarations
  sdc_pkg::sdc_bus_state_t bus_state;
  sdc_pkg::sdc_bus_state_t next_bus_state;
  sdc_pkg::sdc_input_ctl_t input_ctl;
  sdc_pkg::sdc_trim_t      trim;
  logic [31:0]             result_word;
  logic                    result_half_toggle;
  logic [7:0]              preload;
  logic [4:0]              live_vector;
  logic                    bus_req;
  logic                    take;
  logic                    take_rd;
  logic                    take_wr;
  logic                    wr_lo;
  logic                    result_read;
  logic [15:0]             next_readdata;
  logic [15:0]             half_value;

  assign bus_req = avs_read | avs_write;
  // the transfer completes on the edge that sees waitrequest low
  assign take    = bus_req & (bus_state == sdc_pkg::SDC_BUS_ACK);
  assign take_rd = take & avs_read;
  assign take_wr = take & avs_write;
  assign wr_lo   = take_wr & avs_byteenable[0];
  // result read side effects wait for the completing edge, not the
  // wait state, so each read clears the flag once and, with toggle set, flips the select once
  assign result_read = take_rd & hit(avs_address, `SDC_IDX_RESULT);

  // ========================================================================
  // bus phase: one wait state on every access
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      sdc_pkg::SDC_BUS_IDLE: begin
        if (bus_req) begin
          next_bus_state = sdc_pkg::SDC_BUS_ACK;
        end
      end
      sdc_pkg::SDC_BUS_ACK: begin
        next_bus_state = sdc_pkg::SDC_BUS_IDLE;
      end
      default: begin
        next_bus_state = sdc_pkg::SDC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= sdc_pkg::SDC_BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_req && bus_state == sdc_pkg::SDC_BUS_IDLE);
    end
  end

  // ========================================================================
  // conversion result store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_word <= 32'h0000_0000;
    end else if (result_valid) begin
      result_word <= filter_output;
    end
  end

  assign half_value = result_half_select ? result_word[15:0]
                                         : result_word[31:16];

  // ========================================================================
  // half select and toggle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_half_toggle <= 1'b0;
    end else if (wr_lo && hit(avs_address, `SDC_IDX_HALF_CTL)) begin
      result_half_toggle <= avs_writedata[`SDC_HALF_TOG_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_half_select <= 1'b0;
    end else if (wr_lo && hit(avs_address, `SDC_IDX_HALF_CTL)) begin
      result_half_select <= avs_writedata[`SDC_HALF_SEL_BIT];
    end else if (result_read && result_half_toggle) begin
      result_half_select <= !result_half_select;
    end
  end

  // ========================================================================
  // done flag: a new result wins over any clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_done_flag <= 1'b0;
    end else if (result_valid) begin
      conversion_done_flag <= 1'b1;
    end else if (result_read) begin
      conversion_done_flag <= 1'b0;
    end else if (wr_lo && hit(avs_address, `SDC_IDX_HALF_CTL)) begin
      conversion_done_flag <= avs_writedata[`SDC_HALF_DONE_BIT];
    end
  end

  // ========================================================================
  // input control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_ctl <= `SDC_INCTL_RESET;
    end else if (wr_lo && hit(avs_address, `SDC_IDX_INPUT_CTL)) begin
      input_ctl <= avs_writedata[6:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_irq_delay_select <= 1'b0;
      first_irq_sample       <= `SDC_SAMPLE_FOURTH;
    end else begin
      first_irq_delay_select <= input_ctl.first_irq_delay_select;
      first_irq_sample       <= input_ctl.first_irq_delay_select
                                ? `SDC_SAMPLE_FIRST : `SDC_SAMPLE_FOURTH;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preamp_gain_code   <= 3'h0;
      gain_code_reserved <= 1'b0;
    end else begin
      preamp_gain_code   <= input_ctl.preamp_gain_code;
      gain_code_reserved <= input_ctl.preamp_gain_code > `SDC_GAIN_MAX;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_pair_select    <= 3'h0;
      temp_sensor_selected <= 1'b0;
      input_code_reserved  <= 1'b0;
    end else begin
      input_pair_select    <= input_ctl.input_pair_select;
      temp_sensor_selected <= input_ctl.input_pair_select == `SDC_PAIR_TEMP;
      input_code_reserved  <= input_ctl.input_pair_select == `SDC_PAIR_RSVD;
    end
  end

  // ========================================================================
  // filter preload
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preload <= `SDC_PRELOAD_RESET;
    end else if (wr_lo && hit(avs_address, `SDC_IDX_PRELOAD)) begin
      preload <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_preload_value <= `SDC_PRELOAD_RESET;
    end else begin
      filter_preload_value <= preload;
    end
  end

  // ========================================================================
  // trim: kept across ordinary resets, lost only on brown-out
  always_ff @(posedge clk or negedge brown_out_reset_n) begin
    if (!brown_out_reset_n) begin
      trim <= `SDC_TRIM_RESET;
    end else if (wr_lo && hit(avs_address, `SDC_IDX_TRIM)) begin
      trim <= avs_writedata[4:0];
    end
  end

  always_ff @(posedge clk or negedge brown_out_reset_n) begin
    if (!brown_out_reset_n) begin
      // fields cut from the packed reset word so the outputs agree with
      // the register straight after a brown-out
      reference_delay_trim <= 2'(`SDC_TRIM_RESET >> `SDC_TRIM_DLY_LO);
      bias_current_trim    <= 3'(`SDC_TRIM_RESET);
    end else begin
      reference_delay_trim <= trim.reference_delay_trim;
      bias_current_trim    <= trim.bias_current_trim;
    end
  end

  // external reference makes the delay trim irrelevant, so park it at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_delay_trim <= 2'h0;
    end else if (reference_source_select) begin
      applied_delay_trim <= trim.reference_delay_trim;
    end else begin
      applied_delay_trim <= 2'h0;
    end
  end

  // ========================================================================
  // interrupt vector
  // overflow of any channel
  // overflow source carries no channel number
  sdc_irq_vector #(
    .CHANNELS        (CHANNELS)
  ) u_vector (
    .overflow_any    (|overflow_flag),
    .conversion_done ({conversion_done_flag, other_done_flag}),
    .vector_code     (live_vector)
  );

  // registered copy lags the live code by a cycle; bus reads take the
  // live code so software never sees a stale source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_code <= `SDC_VEC_NONE;
    end else begin
      vector_code <= live_vector;
    end
  end

  // ========================================================================
  // read mux; unmapped addresses read zero
  always_comb begin
    next_readdata = 16'h0000;
    if (hit(avs_address, `SDC_IDX_INPUT_CTL)) begin
      next_readdata = {9'h000, input_ctl};
    end else if (hit(avs_address, `SDC_IDX_PRELOAD)) begin
      next_readdata = {8'h00, preload};
    end else if (hit(avs_address, `SDC_IDX_TRIM)) begin
      next_readdata = {11'h000, trim};
    end else if (hit(avs_address, `SDC_IDX_RESULT)) begin
      next_readdata = half_value;
    end else if (hit(avs_address, `SDC_IDX_IRQ_VECTOR)) begin
      next_readdata = {11'h000, live_vector};
    end else if (hit(avs_address, `SDC_IDX_HALF_CTL)) begin
      next_readdata = {13'h0000, conversion_done_flag,
                       result_half_toggle, result_half_select};
    end
  end

  // data is caught during the wait state and held over the completing edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 16'h0000;
    end else if (avs_read && bus_state == sdc_pkg::SDC_BUS_IDLE) begin
      avs_readdata <= next_readdata;
    end
  end

endmodule : sdc_channel6

// ---- sdc_channel6_monitor.sv ----
// assertion checker for the channel-6 register slice
`timescale 1ns/10ps
`include "sdc_regs.svh"
module sdc_channel6_monitor #(
  parameter int CHANNELS   = 7,
  parameter int ADDR_WIDTH = 11
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [15:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic                  result_valid,
  input wire logic [CHANNELS-1:0]   overflow_flag,
  input wire logic [CHANNELS-2:0]   other_done_flag,
  input wire logic                  reference_source_select,
  input wire logic                  conversion_done_flag,
  input wire logic [4:0]            vector_code,
  input wire logic                  first_irq_delay_select,
  input wire logic [2:0]            first_irq_sample,
  input wire logic [2:0]            preamp_gain_code,
  input wire logic                  gain_code_reserved,
  input wire logic [2:0]            input_pair_select,
  input wire logic                  temp_sensor_selected,
  input wire logic                  input_code_reserved,
  input wire logic [1:0]            reference_delay_trim,
  input wire logic [1:0]            applied_delay_trim
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic res_done;
  logic vec_done;
  logic no_src;
  assign res_done = avs_read && !avs_waitrequest
                    && avs_address == {`SDC_IDX_RESULT, 2'b00};
  assign vec_done = avs_read && !avs_waitrequest
                    && avs_address == {`SDC_IDX_IRQ_VECTOR, 2'b00};
  assign no_src = !(|overflow_flag) && !(|other_done_flag);
  // ==========================================================================
  // bus handshake
  sequence s_one_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> s_one_wait) else $error("wait state count wrong");
  a_idle_wait_high: assert property (!(avs_read || avs_write)
    |=> avs_waitrequest) else $error("waitrequest low while idle");
  // ==========================================================================
  // done flag and vector
  a_done_on_result: assert property (result_valid |=> conversion_done_flag)
    else $error("done flag not set by result");
  a_read_clears: assert property (res_done && !result_valid |=>
    !conversion_done_flag) else $error("done flag kept after read");
  a_vec_overflow: assert property (|overflow_flag |=> vector_code == 5'h02)
    else $error("overflow vector wrong");
  a_vec_idle_zero: assert property (no_src && !conversion_done_flag
    |=> vector_code == 5'h00) else $error("vector not zero when idle");
  a_vec_ch6_last: assert property (no_src && conversion_done_flag
    |=> vector_code == 5'h10) else $error("channel 6 vector wrong");
  a_vec_rsvd_zero: assert property (vec_done |-> avs_readdata[15:5] == 11'h000)
    else $error("vector upper bits not zero");
  // ==========================================================================
  // decoded control outputs
  a_sample_pick: assert property (first_irq_sample
    == (first_irq_delay_select ? 3'h1 : 3'h4)) else $error("sample pick wrong");
  a_gain_rsvd: assert property (gain_code_reserved == (preamp_gain_code > 3'h4))
    else $error("gain reserved flag wrong");
  a_pair_codes: assert property (temp_sensor_selected == (input_pair_select
    == 3'h6) && input_code_reserved == (input_pair_select == 3'h7))
    else $error("pair decode wrong");
  // lag of one cycle on both sides keeps this exact
  a_delay_apply: assert property (1'b1 |=> applied_delay_trim
    == ($past(reference_source_select) ? reference_delay_trim : 2'h0))
    else $error("applied delay trim wrong");
endmodule : sdc_channel6_monitor

// ---- sdc_irq_vector.sv ----
// priority encoder for the shared converter interrupt vector
`timescale 1ns/10ps
`include "sdc_regs.svh"

module sdc_irq_vector #(
  parameter int CHANNELS = 7
) (
  input  wire logic                overflow_any,
  input  wire logic [CHANNELS-1:0] conversion_done,
  output logic      [4:0]          vector_code
);

  // ========================================================================
  // encoder: scan from lowest priority up so the highest wins
  always_comb begin
    vector_code = `SDC_VEC_NONE;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (conversion_done[i]) begin
        vector_code = 5'(`SDC_VEC_CH0 + `SDC_VEC_STEP * i);
      end
    end
    if (overflow_any) begin
      vector_code = `SDC_VEC_OVERFLOW;
    end
  end

endmodule : sdc_irq_vector

// ---- sdc_pkg.sv ----
// types shared by the channel-6 register slice
package sdc_pkg;

  // ========================================================================
  // input control layout
  typedef struct packed {
    logic       first_irq_delay_select;
    logic [2:0] preamp_gain_code;
    logic [2:0] input_pair_select;
  } sdc_input_ctl_t;

  // ========================================================================
  // trim layout
  typedef struct packed {
    logic [1:0] reference_delay_trim;
    logic [2:0] bias_current_trim;
  } sdc_trim_t;

  // ========================================================================
  // gain codes
  typedef enum logic [2:0] {
    SDC_GAIN_X1  = 3'h0,
    SDC_GAIN_X2  = 3'h1,
    SDC_GAIN_X4  = 3'h2,
    SDC_GAIN_X8  = 3'h3,
    SDC_GAIN_X16 = 3'h4
  } sdc_gain_t;

  // ========================================================================
  // bus phase, one-hot
  typedef enum logic [1:0] {
    SDC_BUS_IDLE = 2'b01,
    SDC_BUS_ACK  = 2'b10
  } sdc_bus_state_t;

endpackage : sdc_pkg

// ---- sdc_regs.svh ----
// register offsets, field positions, reset values for the channel-6 slice
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// ==========================================================================
// register indexes (byte address is four times the index)
`define SDC_IDX_INPUT_CTL     9'h0B6
`define SDC_IDX_PRELOAD       9'h0BE
`define SDC_IDX_TRIM          9'h0BF
`define SDC_IDX_RESULT        9'h11C
`define SDC_IDX_IRQ_VECTOR    9'h1AE
`define SDC_IDX_HALF_CTL      9'h1C0

// ==========================================================================
// input control fields
`define SDC_INCTL_DLY_BIT     6
`define SDC_INCTL_GAIN_HI     5
`define SDC_INCTL_GAIN_LO     3
`define SDC_INCTL_PAIR_HI     2
`define SDC_INCTL_PAIR_LO     0
`define SDC_INCTL_RESET       7'h00

// ==========================================================================
// half control fields
`define SDC_HALF_SEL_BIT      0
`define SDC_HALF_TOG_BIT      1
`define SDC_HALF_DONE_BIT     2

// ==========================================================================
// trim fields
`define SDC_TRIM_DLY_HI       4
`define SDC_TRIM_DLY_LO       3
`define SDC_TRIM_BIAS_HI      2
`define SDC_TRIM_BIAS_LO      0
`define SDC_TRIM_RESET        5'h0C

// ==========================================================================
// misc values
`define SDC_PRELOAD_RESET     8'h00
`define SDC_VEC_NONE          5'h00
`define SDC_VEC_OVERFLOW      5'h02
`define SDC_VEC_CH0           5'h04
`define SDC_VEC_STEP          5'h02
`define SDC_GAIN_MAX          3'h4
`define SDC_PAIR_TEMP         3'h6
`define SDC_PAIR_RSVD         3'h7
`define SDC_SAMPLE_FIRST      3'h1
`define SDC_SAMPLE_FOURTH     3'h4

`endif

// ---- tb_sdc.sv ----
// self-checking bench for the channel-6 register slice
`timescale 1ns/10ps
`include "sdc_regs.svh"
module tb;
  logic        clk, rst_n, bor_n, rd_en, wr_en, rvalid, rss;
  logic [10:0] addr;
  logic [15:0] wdata, rdata;
  logic [1:0]  be, rdly, adly;
  logic [31:0] fout;
  logic [6:0]  ovf;
  logic [5:0]  odone;
  logic        wait_req, done, hsel, dly, grsv, temp, prsv;
  logic [4:0]  vcode;
  logic [2:0]  fsample, gain, pair, bias;
  logic [7:0]  pre;
  int          n_mismatch, n_checks;

  sdc_channel6 u_dut (
    .clk(clk), .rst_n(rst_n), .brown_out_reset_n(bor_n),
    .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .filter_output(fout),
    .result_valid(rvalid), .overflow_flag(ovf), .other_done_flag(odone),
    .reference_source_select(rss), .conversion_done_flag(done),
    .result_half_select(hsel), .vector_code(vcode),
    .first_irq_delay_select(dly), .first_irq_sample(fsample),
    .preamp_gain_code(gain), .gain_code_reserved(grsv),
    .input_pair_select(pair), .temp_sensor_selected(temp),
    .input_code_reserved(prsv), .filter_preload_value(pre),
    .reference_delay_trim(rdly), .applied_delay_trim(adly),
    .bias_current_trim(bias));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================================================
  // bus tasks
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one idle edge after release so registered outputs have landed
  task automatic bus(input logic [8:0] idx, input logic w,
                     input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd_en <= !w;
    wr_en <= w;
    wdata <= d;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (wait_req === 1'b0) break;
    end
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
    if (n == 16) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : bus

  task automatic wr(input logic [8:0] idx, input logic [15:0] d);
    logic [15:0] q;
    bus(idx, 1'b1, d, q);
  endtask : wr

  task automatic rdc(input logic [8:0] idx, input logic [15:0] e);
    logic [15:0] q;
    bus(idx, 1'b0, 16'h0000, q);
    chk(q, e);
  endtask : rdc
  // ==========================================================================
  // main sequence
  initial begin
    {rst_n, bor_n, rd_en, wr_en, rvalid, rss} = 6'h00;
    {addr, wdata, fout, ovf, odone} = '0;
    be = 2'h3;
    n_mismatch = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    bor_n <= 1'b1;
    rdc(`SDC_IDX_INPUT_CTL, 16'h0000);
    rdc(`SDC_IDX_PRELOAD, 16'h0000);
    rdc(`SDC_IDX_TRIM, 16'h000C);
    rdc(`SDC_IDX_RESULT, 16'h0000);
    rdc(`SDC_IDX_IRQ_VECTOR, 16'h0000);
    for (int g = 0; g < 8; g++) begin
      wr(`SDC_IDX_INPUT_CTL, {8'h00, 2'h3, g[2:0], g[2:0]});
      rdc(`SDC_IDX_INPUT_CTL, {9'h000, 1'b1, g[2:0], g[2:0]});
      chk(gain, g[2:0]);
      chk(grsv, g > 4);
      chk(pair, g[2:0]);
      chk(temp, g == 6);
      chk(prsv, g == 7);
      chk(fsample, 3'h1);
      chk(dly, 1'b1);
    end
    wr(`SDC_IDX_INPUT_CTL, 16'h0000);
    rdc(`SDC_IDX_INPUT_CTL, 16'h0000);
    chk(fsample, 3'h4);
    chk(dly, 1'b0);
    wr(`SDC_IDX_PRELOAD, 16'h00A5);
    be <= 2'h2;
    wr(`SDC_IDX_PRELOAD, 16'h005A);
    be <= 2'h3;
    rdc(`SDC_IDX_PRELOAD, 16'h00A5);
    chk(pre, 8'hA5);
    wr(9'h001, 16'h00FF);
    rdc(9'h001, 16'h0000);
    wr(`SDC_IDX_TRIM, 16'h00FF);
    rdc(`SDC_IDX_TRIM, 16'h001F);
    chk(rdly, 2'h3);
    chk(bias, 3'h7);
    chk(adly, 2'h0);
    rss <= 1'b1;
    repeat (2) @(posedge clk);
    chk(adly, 2'h3);
    rss <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rdc(`SDC_IDX_TRIM, 16'h001F);
    chk(rdly, 2'h3);
    bor_n <= 1'b0;
    @(posedge clk);
    bor_n <= 1'b1;
    rdc(`SDC_IDX_TRIM, 16'h000C);
    chk(bias, 3'h4);
    chk(rdly, 2'h1);
    fout <= 32'h1234ABCD;
    rvalid <= 1'b1;
    @(posedge clk);
    rvalid <= 1'b0;
    @(posedge clk);
    chk(done, 1'b1);
    rdc(`SDC_IDX_IRQ_VECTOR, 16'h0010);
    rdc(`SDC_IDX_RESULT, 16'h1234);
    chk(done, 1'b0);
    wr(`SDC_IDX_HALF_CTL, 16'h0003);
    rdc(`SDC_IDX_RESULT, 16'hABCD);
    chk(hsel, 1'b0);
    rdc(`SDC_IDX_RESULT, 16'h1234);
    chk(hsel, 1'b1);
    wr(`SDC_IDX_HALF_CTL, 16'h0001);
    rdc(`SDC_IDX_RESULT, 16'hABCD);
    chk(hsel, 1'b1);
    wr(`SDC_IDX_HALF_CTL, 16'h0005);
    chk(done, 1'b1);
    wr(`SDC_IDX_HALF_CTL, 16'h0001);
    chk(done, 1'b0);
    rvalid <= 1'b1;
    @(posedge clk);
    rvalid <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      odone <= 6'h3F << i;
      repeat (3) @(posedge clk);
      chk(vcode, 5'h04 + 5'(2 * i));
      rdc(`SDC_IDX_IRQ_VECTOR, 16'h0004 + 16'(2 * i));
    end
    // overflow must win over every done source
    for (int k = 0; k < 7; k++) begin
      ovf <= 7'h01 << k;
      odone <= 6'h3F;
      repeat (2) @(posedge clk);
      chk(vcode, 5'h02);
      // same code for every channel: software must scan the flags
      rdc(`SDC_IDX_IRQ_VECTOR, 16'h0002);
    end
    ovf <= 7'h00;
    odone <= 6'h00;
    wr(`SDC_IDX_HALF_CTL, 16'h0000);
    repeat (2) @(posedge clk);
    chk(vcode, 5'h00);
    tally_and_finish();
  end
endmodule : tb

bind sdc_channel6 sdc_channel6_monitor #(
  .CHANNELS(CHANNELS), .ADDR_WIDTH(ADDR_WIDTH)
) u_mon (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .result_valid(result_valid), .overflow_flag(overflow_flag),
  .other_done_flag(other_done_flag),
  .reference_source_select(reference_source_select),
  .conversion_done_flag(conversion_done_flag), .vector_code(vector_code),
  .first_irq_delay_select(first_irq_delay_select),
  .first_irq_sample(first_irq_sample), .preamp_gain_code(preamp_gain_code),
  .gain_code_reserved(gain_code_reserved),
  .input_pair_select(input_pair_select),
  .temp_sensor_selected(temp_sensor_selected),
  .input_code_reserved(input_code_reserved),
  .reference_delay_trim(reference_delay_trim),
  .applied_delay_trim(applied_delay_trim));
